/* rtl/umls_top.sv */
// Modem control, line status, modem status, scratch and flow levels of a UART
`timescale 1ns/1ns
module umls_top
  import umls_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  input  wire logic         enhanced_en,
  input  wire logic         fifo_mode,
  input  wire logic         auto_rts_en,
  input  wire logic         auto_cts_en,
  input  wire logic         sw_flow_en,
  input  wire logic         half_duplex_en,
  input  wire logic         half_duplex_drive,
  input  wire logic         msi_enable,
  input  wire logic         cts_n,
  input  wire logic         dsr_n,
  input  wire logic         ring_indicator_n,
  input  wire logic         carrier_detect_n,
  input  wire logic         rx_line,
  input  wire umls_rx_evt_t rx_evt,
  input  wire logic         rx_pop,
  input  wire umls_tags_t   rx_head,
  input  wire logic [6:0]   rx_level,
  input  wire logic [6:0]   tx_level,
  input  wire logic         thr_load,
  input  wire logic         thr_to_tsr,
  input  wire logic         tsr_busy,
  output logic              dtr_n,
  output logic              rts_n,
  output logic              modem_irq,
  output logic              loopback,
  output logic              rx_push,
  output umls_tags_t        rx_push_tags,
  output logic              xon_any_resume,
  output logic              send_xoff,
  output logic              send_xon,
  output logic              tx_halt,
  output logic              baud_clk_en,
  output logic      [7:0]   trig_levels
);

  // Software-visible storage
  logic [7:0] mcr_r;
  logic [7:0] spr_r;
  logic [7:0] tcr_r;
  logic [7:0] tlr_r;
  logic       thre_r;
  logic       oe_r;
  logic       brk_hold_r;
  logic [6:0] err_cnt_r;
  umls_flow_t flow_r;
  umls_flow_t flow_nxt;
  logic [3:0] msr_delta;
  logic [7:0] rdata_nxt;

  // Register decode; offsets 6 and 7 switch on enhanced enable and bit 2
  wire sel_alt = enhanced_en && mcr_r[MCR_OP1];
  wire at_mcr  = (reg_addr == OFS_MCR);
  wire at_lsr  = (reg_addr == OFS_LSR);
  wire at_six  = (reg_addr == OFS_MSR);
  wire at_sev  = (reg_addr == OFS_SPR);
  wire wr_mcr  = reg_wr && at_mcr;
  wire wr_tcr  = reg_wr && at_six && sel_alt;
  wire wr_spr  = reg_wr && at_sev && !sel_alt;
  wire wr_tlr  = reg_wr && at_sev && sel_alt;
  wire rd_lsr  = reg_rd && at_lsr;
  wire rd_msr  = reg_rd && at_six && !sel_alt;

  // Enhanced-only bits keep their value when the enable is off
  wire [7:0] mcr_mask = enhanced_en ? MCR_WMASK_ENH : MCR_WMASK_STD;
  wire [7:0] mcr_nxt  = (mcr_r & ~mcr_mask) | (reg_wdata & mcr_mask);
  wire       loop_on  = mcr_r[MCR_LOOP];

  // Status inputs; loopback feeds them from the control bits instead
  wire [3:0] pin_st  = {~carrier_detect_n, ~ring_indicator_n, ~dsr_n, ~cts_n};
  wire [3:0] loop_st = {mcr_r[MCR_OP2], mcr_r[MCR_OP1],
                        mcr_r[MCR_DTR], mcr_r[MCR_RTS]};
  wire [3:0] msr_st  = loop_on ? loop_st : pin_st;
  wire [7:0] msr_val = {msr_st, msr_delta};

  // Receive side: full FIFO drops the character, repeated breaks too
  wire rx_full   = (rx_level == RX_DEPTH);
  wire rx_flowch = rx_evt.is_xonoff && sw_flow_en;
  wire rx_rebrk  = rx_evt.brk && brk_hold_r;
  wire push_now  = rx_evt.done && !rx_full && !rx_flowch && !rx_rebrk;
  wire evt_tag   = rx_evt.brk || rx_evt.frame_err || rx_evt.parity_err;
  wire have_rx   = (rx_level != 7'h00);
  wire head_tag  = have_rx && (rx_head.brk || rx_head.frame_err || rx_head.parity_err);
  wire err_inc   = push_now && evt_tag;
  wire err_dec   = rx_pop && head_tag;

  // Line status word; head tags belong to the character now readable
  wire thre_now = fifo_mode ? (tx_level == 7'h00) : thre_r;
  wire temt_now = thre_now && !tsr_busy;
  wire [7:0] lsr_val = {
    err_cnt_r != 7'h00,
    temt_now,
    thre_now,
    have_rx && rx_head.brk,
    have_rx && rx_head.frame_err,
    have_rx && rx_head.parity_err,
    oe_r,
    have_rx
  };

  // Halt and resume thresholds in characters, nibble times four
  wire [6:0] halt_lvl   = {1'b0, tcr_r[3:0], 2'b00};
  wire [6:0] resume_lvl = {1'b0, tcr_r[7:4], 2'b00};

  // Halt check first, so a crossed pair of levels stays halted
  always_comb
  begin
    flow_nxt = flow_r;
    case (flow_r)
      FLOW_RUN:
        if (rx_level >= halt_lvl)
          flow_nxt = FLOW_HALT;
      FLOW_HALT:
        if (rx_level <= resume_lvl && rx_level < halt_lvl)
          flow_nxt = FLOW_RUN;
      default:
        flow_nxt = FLOW_RUN;
    endcase
  end

  // Request-to-send owner: direction control, then auto flow, then software
  wire rts_n_nxt = half_duplex_en ? !half_duplex_drive :
                   auto_rts_en    ? (flow_nxt == FLOW_HALT) :
                                    !mcr_r[MCR_RTS];

  // Read data mux; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (at_mcr)
      rdata_nxt = mcr_r;
    else if (at_lsr)
      rdata_nxt = lsr_val;
    else if (at_six)
      rdata_nxt = sel_alt ? tcr_r : msr_val;
    else if (at_sev)
      rdata_nxt = sel_alt ? tlr_r : spr_r;
  end

  // Control and storage registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mcr_r <= MCR_RESET;
      spr_r <= SPR_RESET;
      tcr_r <= TCR_RESET;
      tlr_r <= TLR_RESET;
    end
    else
    begin
      if (wr_mcr)
        mcr_r <= mcr_nxt;
      if (wr_spr)
        spr_r <= reg_wdata;
      if (wr_tcr)
        tcr_r <= reg_wdata;
      if (wr_tlr)
        tlr_r <= reg_wdata;
    end
  end

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      thre_r <= 1'b1;
      oe_r   <= 1'b0;
    end
    else
    begin
      if (thr_to_tsr)
        thre_r <= 1'b1;
      else if (thr_load)
        thre_r <= 1'b0;
      if (rx_evt.done && rx_full)
        oe_r <= 1'b1;
      else if (rd_lsr)
        oe_r <= 1'b0;
    end
  end

  // Break hold lasts until the line returns to mark
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      brk_hold_r <= 1'b0;
    else if (push_now && rx_evt.brk)
      brk_hold_r <= 1'b1;
    else if (rx_line)
      brk_hold_r <= 1'b0;
  end

  // Count of tagged bytes inside the FIFO drives the summary flag
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      err_cnt_r <= 7'h00;
    else if (err_inc && !err_dec)
      err_cnt_r <= err_cnt_r + 7'h01;
    else if (err_dec && !err_inc && err_cnt_r != 7'h00)
      err_cnt_r <= err_cnt_r - 7'h01;
  end

  // Flow state and the Xon/Xoff requests made on its changes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flow_r    <= FLOW_RUN;
      send_xoff <= 1'b0;
      send_xon  <= 1'b0;
    end
    else
    begin
      flow_r    <= flow_nxt;
      send_xoff <= sw_flow_en && flow_r == FLOW_RUN && flow_nxt == FLOW_HALT;
      send_xon  <= sw_flow_en && flow_r == FLOW_HALT && flow_nxt == FLOW_RUN;
    end
  end

  // Registered outputs; the transmitter finishes its character on halt
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata      <= 8'h00;
      dtr_n          <= 1'b1;
      rts_n          <= 1'b1;
      modem_irq      <= 1'b0;
      loopback       <= 1'b0;
      rx_push        <= 1'b0;
      rx_push_tags   <= '0;
      xon_any_resume <= 1'b0;
      tx_halt        <= 1'b0;
      trig_levels    <= TLR_RESET;
    end
    else
    begin
      reg_rdata      <= reg_rd ? rdata_nxt : 8'h00;
      dtr_n          <= !mcr_r[MCR_DTR];
      rts_n          <= rts_n_nxt;
      modem_irq      <= msi_enable && (msr_delta != 4'h0);
      loopback       <= loop_on;
      rx_push        <= push_now;
      rx_push_tags   <= {rx_evt.brk, rx_evt.frame_err, rx_evt.parity_err};
      xon_any_resume <= mcr_r[MCR_XANY] && rx_evt.done;
      tx_halt        <= auto_cts_en && !msr_st[0];
      trig_levels    <= tlr_r;
    end
  end

  umls_delta u_delta (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .status  (msr_st),
    .clear   (rd_msr),
    .delta   (msr_delta)
  );

  umls_prescale u_prescale (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .div4    (mcr_r[MCR_PRE]),
    .tick_en (baud_clk_en)
  );

  // Checks on the block's outputs and internal state
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_dtr_follows_bit: assert property (
    $rose(mcr_r[MCR_DTR]) |=> !dtr_n)
    else $error("terminal-ready did not go low");

  a_rts_manual_bit: assert property (
    (!half_duplex_en && !auto_rts_en && $fell(mcr_r[MCR_RTS])) |=> rts_n)
    else $error("request-to-send did not go high");

  a_loop_ring_mirror: assert property (
    (loop_on && rd_msr) |=> reg_rdata[6] == $past(mcr_r[MCR_OP1]))
    else $error("loopback ring status wrong");

  a_scratch_readback: assert property (
    (wr_spr ##1 (reg_rd && at_sev && !sel_alt && !reg_wr)) |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("scratch readback mismatch");

  a_overrun_drop: assert property (
    (rx_evt.done && rx_full) |=> (oe_r && !rx_push))
    else $error("overrun not flagged or data pushed");

  a_halt_level: assert property (
    (reset_n && rx_level >= halt_lvl) |=> flow_r == FLOW_HALT)
    else $error("halt level not honoured");

  a_resume_level: assert property (
    (flow_r == FLOW_HALT && rx_level <= resume_lvl && rx_level < halt_lvl)
      |=> flow_r == FLOW_RUN)
    else $error("resume level not honoured");

  a_prescale_gap: assert property (
    (mcr_r[MCR_PRE] && baud_clk_en) ##1 mcr_r[MCR_PRE] |-> !baud_clk_en)
    else $error("divided tick too close");

  a_temt_busy: assert property (
    (rd_lsr && tsr_busy) |=> !reg_rdata[6])
    else $error("transmitter empty while shifting");

  a_cts_halt: assert property (
    (auto_cts_en && cts_n && !loop_on) |=> tx_halt)
    else $error("auto clear-to-send did not halt");

  a_msr_read_clr: assert property (
    (rd_msr && $stable(msr_st)) |=> msr_delta == 4'h0)
    else $error("delta flags not cleared by read");

  a_flow_char_drop: assert property (
    (rx_evt.done && rx_evt.is_xonoff && sw_flow_en) |=> !rx_push)
    else $error("flow character entered the receive queue");

  a_lsr_ready: assert property (
    (rd_lsr && rx_level != 7'h00) |=> reg_rdata[0])
    else $error("data-ready clear while characters wait");

  a_delta_irq: assert property (
    (msi_enable && msr_delta != 4'h0) |=> modem_irq)
    else $error("modem interrupt missing after a delta");

  c_overrun: cover property (rx_evt.done && rx_full);
  c_flow_halt: cover property (sw_flow_en && send_xoff ##[1:200] send_xon);
  c_loop_read: cover property (loop_on && rd_msr && msr_delta != 4'h0);
  c_break_drop: cover property (rx_evt.done && rx_rebrk);
  c_scratch_b2b: cover property (wr_spr ##1 (reg_rd && at_sev));

endmodule

/* rtl/umls_pkg.sv */
// Constants, types and register map of the modem/line status block
package umls_pkg;
  localparam logic [3:0] OFS_MCR = 4'h4;   // Modem output control
  localparam logic [3:0] OFS_LSR = 4'h5;   // Line status
  localparam logic [3:0] OFS_MSR = 4'h6;   // Modem status, or halt/resume levels
  localparam logic [3:0] OFS_SPR = 4'h7;   // Scratch, or trigger levels

  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_OP1  = 2;
  localparam int MCR_OP2  = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_XANY = 5;
  localparam int MCR_PRE  = 7;

  // Bits 5 and 7 need the enhanced enable; bit 6 stays reserved
  localparam logic [7:0] MCR_WMASK_STD = 8'h1f;
  localparam logic [7:0] MCR_WMASK_ENH = 8'hbf;

  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] SPR_RESET = 8'hff;
  localparam logic [7:0] TCR_RESET = 8'h00;
  localparam logic [7:0] TLR_RESET = 8'h00;

  localparam logic [6:0] RX_DEPTH  = 7'h40;  // Receive FIFO full count
  localparam logic [1:0] PRESCALE  = 2'h3;   // Divide by four: count 0..3

  typedef enum logic [1:0] {
    FLOW_RUN  = 2'b01,
    FLOW_HALT = 2'b10
  } umls_flow_t;

  // One completed receive character from the shift stage
  typedef struct packed {
    logic done;
    logic is_xonoff;
    logic brk;
    logic frame_err;
    logic parity_err;
  } umls_rx_evt_t;

  // Error tags carried by a FIFO byte
  typedef struct packed {
    logic brk;
    logic frame_err;
    logic parity_err;
  } umls_tags_t;
endpackage

/* rtl/umls_prescale.sv */
// Baud clock prescaler: enable pulse every cycle or every fourth cycle
`timescale 1ns/1ns
module umls_prescale
  import umls_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic div4,
  output logic      tick_en
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  wire        wrap = (cnt_r == PRESCALE);

  // Counter rests at zero in divide-by-one so a switch starts clean
  assign cnt_nxt = (!div4 || wrap) ? 2'h0 : cnt_r + 2'h1;

  // Registered enable; consumers see one pulse per divided period
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r   <= 2'h0;
      tick_en <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      tick_en <= !div4 || wrap;
    end
  end
endmodule

/* rtl/umls_delta.sv */
// Change detectors for the four modem status lines, cleared by a read
`timescale 1ns/1ns
module umls_delta
  import umls_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [3:0] status,
  input  wire logic       clear,
  output logic      [3:0] delta
);
  logic [3:0] prev_r;
  logic       primed_r;
  logic [3:0] hit;

  // Ring (index 2) counts only the pin rising, i.e. status falling
  for (genvar i = 0; i < 4; i++)
  begin : g_line
    if (i == 2)
    begin : g_ring
      assign hit[i] = primed_r && prev_r[i] && !status[i];
    end
    else
    begin : g_edge
      assign hit[i] = primed_r && (prev_r[i] != status[i]);
    end

    // A change in the read cycle survives the clear
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        delta[i] <= 1'b0;
      else if (hit[i])
        delta[i] <= 1'b1;
      else if (clear)
        delta[i] <= 1'b0;
    end
  end

  // First sample after reset only primes the history, no false delta
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_r   <= 4'h0;
      primed_r <= 1'b0;
    end
    else
    begin
      prev_r   <= status;
      primed_r <= 1'b1;
    end
  end
endmodule

/* dv/umls_modem.sv */
// Behavioural remote modem driving the modem status pins and receive line
`timescale 1ns/1ns
module umls_modem
(
  input  wire logic       clk_sys,
  input  wire logic [4:0] want,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ring_indicator_n,
  output logic            carrier_detect_n,
  output logic            rx_line
);
  // Pins move just after an edge, as the block takes them as synchronous
  always_ff @(posedge clk_sys)
  begin
    {rx_line, carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= want;
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the modem control and line status block
`timescale 1ns/1ns
module tb_top;
  import umls_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset_n = 1'b0;
  logic [3:0]   reg_addr = 4'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]   reg_rdata, trig_levels, d;
  logic         enhanced_en = 1'b0, fifo_mode = 1'b0, auto_rts_en = 1'b0;
  logic         auto_cts_en = 1'b0, sw_flow_en = 1'b0, half_duplex_en = 1'b0;
  logic         half_duplex_drive = 1'b0, msi_enable = 1'b0, rx_pop = 1'b0;
  logic         thr_load = 1'b0, thr_to_tsr = 1'b0, tsr_busy = 1'b0;
  logic         cts_n, dsr_n, ring_indicator_n, carrier_detect_n, rx_line;
  logic [4:0]   want = 5'h1f;
  umls_rx_evt_t rx_evt = '0;
  umls_tags_t   rx_head = '0;
  umls_tags_t   rx_push_tags, last_tags;
  logic [6:0]   rx_level = 7'h00, tx_level = 7'h00;
  logic         dtr_n, rts_n, modem_irq, loopback, rx_push, xon_any_resume;
  logic         send_xoff, send_xon, tx_halt, baud_clk_en;
  int           error_cnt = 0, samples_checked = 0, n;
  int           push_cnt = 0, xany_cnt = 0, xoff_cnt = 0, xon_cnt = 0;

  always #25 clk_sys = ~clk_sys;

  umls_top uut (.*);
  umls_modem far_end (.*);

  // Count the one-cycle pulses so that a late look cannot miss them
  always @(posedge clk_sys)
  begin
    push_cnt <= push_cnt + rx_push;
    xany_cnt <= xany_cnt + xon_any_resume;
    xoff_cnt <= xoff_cnt + send_xoff;
    xon_cnt  <= xon_cnt + send_xon;
    if (rx_push === 1'b1)
      last_tags <= rx_push_tags;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  // Register bus: one-cycle strobes launched right after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Pin order is {rx_line, carrier, ring, dsr, cts}; wait covers history and delta
  task automatic pins(input logic [4:0] v);
    @(posedge clk_sys);
    want <= v;
    tk(5);
  endtask

  task automatic rx(input logic [4:0] e);
    @(posedge clk_sys);
    rx_evt <= e;
    @(posedge clk_sys);
    rx_evt <= '0;
    tk(2);
  endtask

  task automatic transmit_holding_register(input logic [1:0] v);
    @(posedge clk_sys);
    {thr_load, thr_to_tsr} <= v;
    @(posedge clk_sys);
    {thr_load, thr_to_tsr} <= 2'b00;
    tk(1);
  endtask

  // Enables are counted over a whole number of divider periods
  task automatic baud(input logic [7:0] exp);
    logic [7:0] k;
    k = 8'h00;
    // Sample after the edge so the enable is settled, not racing its launch
    repeat (8)
    begin
      tk(1);
      k = k + {7'h0, baud_clk_en};
    end
    chk(k, exp);
  endtask

  // Watchdog: a hang is a failure, not a silent stall
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    tk(3);
    chk({6'h0, dtr_n, rts_n}, 8'h03);
    rd(OFS_SPR);
    chk(d, 8'hff);
    rd(OFS_LSR);
    chk(d, 8'h60);
    rd(OFS_MSR);
    chk(d, 8'h00);
    baud(8'h08);
    // Without the enhanced enable bits 5 and 7 must not stick
    wr(OFS_MCR, 8'hff);
    tk(4);
    rd(OFS_MCR);
    chk(d, 8'h1f);
    chk({7'h0, loopback}, 8'h01);
    chk({6'h0, dtr_n, rts_n}, 8'h00);
    rd(OFS_MSR);
    chk(d, 8'hfb);
    rd(OFS_MSR);
    chk(d, 8'hf0);
    wr(OFS_MCR, 8'h1b);
    tk(4);
    rd(OFS_MSR);
    chk(d, 8'hb4);
    @(posedge clk_sys) enhanced_en <= 1'b1;
    wr(OFS_MCR, 8'hff);
    rd(OFS_MCR);
    chk(d, 8'hbf);
    baud(8'h02);
    // Shared offsets: level registers only with enable and bit 2
    wr(OFS_MSR, 8'h12);
    wr(OFS_SPR, 8'h5a);
    rd(OFS_MSR);
    chk(d, 8'h12);
    rd(OFS_SPR);
    chk(d, 8'h5a);
    chk(trig_levels, 8'h5a);
    @(posedge clk_sys) enhanced_en <= 1'b0;
    rd(OFS_SPR);
    chk(d, 8'hff);
    wr(OFS_SPR, 8'h3c);
    wr(OFS_MSR, 8'h77);
    rd(OFS_SPR);
    chk(d, 8'h3c);
    // Write then read with no gap between the two strobes
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= OFS_SPR;
    reg_wdata <= 8'ha5;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, 8'ha5);
    wr(4'hf, 8'h55);
    rd(4'hf);
    chk(d, 8'h00);
    @(posedge clk_sys) enhanced_en <= 1'b1;
    wr(OFS_MCR, 8'h20);
    tk(4);
    chk({6'h0, dtr_n, rts_n}, 8'h03);
    rd(OFS_MSR);
    rd(OFS_MSR);
    chk(d, 8'h00);
    // Modem inputs: deltas, ring trailing edge only, clear on read
    @(posedge clk_sys) msi_enable <= 1'b1;
    pins(5'h1e);
    n = 0;
    while (modem_irq !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 10)
    begin
      error_cnt++;
      end_of_test();
    end
    rd(OFS_MSR);
    chk(d, 8'h11);
    tk(3);
    chk({7'h0, modem_irq}, 8'h00);
    pins(5'h1a);
    rd(OFS_MSR);
    chk(d, 8'h50);
    pins(5'h1e);
    rd(OFS_MSR);
    chk(d, 8'h14);
    pins(5'h14);
    rd(OFS_MSR);
    chk(d, 8'hba);
    @(posedge clk_sys) auto_cts_en <= 1'b1;
    pins(5'h15);
    chk({7'h0, tx_halt}, 8'h01);
    pins(5'h14);
    chk({7'h0, tx_halt}, 8'h00);
    // Direction control, then halt 8 and resume 4 with hysteresis
    @(posedge clk_sys) half_duplex_en <= 1'b1;
    half_duplex_drive <= 1'b1;
    tk(3);
    chk({7'h0, rts_n}, 8'h00);
    @(posedge clk_sys) half_duplex_drive <= 1'b0;
    tk(3);
    chk({7'h0, rts_n}, 8'h01);
    @(posedge clk_sys) half_duplex_en <= 1'b0;
    auto_rts_en <= 1'b1;
    sw_flow_en  <= 1'b1;
    tk(3);
    chk({7'h0, rts_n}, 8'h00);
    for (int i = 7; i >= 4; i--)
    begin
      @(posedge clk_sys) rx_level <= (i == 6) ? 7'd8 : 7'(i);
      tk(4);
      chk({7'h0, rts_n}, (i == 4 || i == 7) ? 8'h00 : 8'h01);
    end
    chk(8'(xoff_cnt), 8'h01);
    chk(8'(xon_cnt), 8'h01);
    // Receive path: tags, flow characters, summary, overrun, break
    @(posedge clk_sys) rx_level <= 7'h00;
    rx(5'h13);
    chk(8'(push_cnt), 8'h01);
    chk(8'(xany_cnt), 8'h01);
    chk({5'h0, last_tags}, 8'h03);
    @(posedge clk_sys) rx_level <= 7'h01;
    rx_head <= 3'b011;
    tk(2);
    rd(OFS_LSR);
    chk(d, 8'hed);
    @(posedge clk_sys) rx_pop <= 1'b1;
    @(posedge clk_sys) rx_pop <= 1'b0;
    rx_level <= 7'h00;
    rx_head  <= 3'b000;
    tk(2);
    rd(OFS_LSR);
    chk(d, 8'h60);
    rx(5'h18);
    chk(8'(push_cnt), 8'h01);
    chk(8'(xany_cnt), 8'h02);
    @(posedge clk_sys) rx_level <= 7'h40;
    rx(5'h10);
    chk(8'(push_cnt), 8'h01);
    rd(OFS_LSR);
    chk(d & 8'h03, 8'h03);
    rd(OFS_LSR);
    chk(d & 8'h03, 8'h01);
    @(posedge clk_sys) rx_level <= 7'h00;
    pins(5'h04);
    rx(5'h14);
    rx(5'h14);
    chk(8'(push_cnt), 8'h02);
    pins(5'h14);
    rx(5'h14);
    chk(8'(push_cnt), 8'h03);
    chk({5'h0, last_tags}, 8'h04);
    // Transmit flags, holding register mode then FIFO mode
    transmit_holding_register(2'b10);
    rd(OFS_LSR);
    chk(d & 8'h60, 8'h00);
    @(posedge clk_sys) tsr_busy <= 1'b1;
    transmit_holding_register(2'b01);
    rd(OFS_LSR);
    chk(d & 8'h60, 8'h20);
    @(posedge clk_sys) tsr_busy <= 1'b0;
    rd(OFS_LSR);
    chk(d & 8'h60, 8'h60);
    @(posedge clk_sys) fifo_mode <= 1'b1;
    tx_level <= 7'h03;
    rd(OFS_LSR);
    chk(d & 8'h60, 8'h00);
    @(posedge clk_sys) tx_level <= 7'h00;
    rd(OFS_LSR);
    chk(d & 8'h60, 8'h60);
    end_of_test();
  end
endmodule
